//--- verilog/sdram_pin_front.sv
`timescale 1ns/10ps
// device-side pin decode: command, bank, row, column, flags, byte masks and data bus
module sdram_pin_front #(
  parameter int ADDR_W = sdram_pin_pkg::ADDR_W,
  parameter int DATA_W = sdram_pin_pkg::DATA_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_bit0,
  input wire logic bank_select_bit1,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic [DATA_W-1:0] data_bus_in,
  output logic [DATA_W-1:0] data_bus_out,
  output logic [1:0] data_bus_oe,
  output logic [sdram_pin_pkg::BANK_W+ADDR_W-1:0] mode_op_code,
  output logic mode_load,
  output logic [sdram_pin_pkg::NUM_BANKS-1:0] bank_open,
  output logic [sdram_pin_pkg::NUM_BANKS-1:0] precharge_done,
  output logic auto_precharge
);
  localparam int BW = sdram_pin_pkg::BANK_W;
  localparam int NB = sdram_pin_pkg::NUM_BANKS;
  localparam int CW = sdram_pin_pkg::COL_W;
  localparam int MAW = sdram_pin_pkg::MEM_AW;
  localparam int LAT = sdram_pin_pkg::MASK_LAT;

  typedef enum {IDLE, WR_BURST, RD_BURST} burst_t;

  // stage 1: all pins registered on the rising edge
  sdram_pin_pkg::pins_t pins_reg, pins_next;
  always_comb begin
    pins_next = '{cs_n: cs_n, ras_n: ras_n, cas_n: cas_n, we_n: we_n,
                  bank_select_bit1: bank_select_bit1, bank_select_bit0: bank_select_bit0,
                  addr: addr, high_byte_mask: high_byte_mask,
                  low_byte_mask: low_byte_mask};
  end
  logic [DATA_W-1:0] din_reg;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_reg <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      din_reg <= '0;
    end else begin
      pins_reg <= pins_next;
      din_reg <= data_bus_in;
    end
  end

  sdram_pin_pkg::cmd_t cmd;
  logic [BW-1:0] bank;
  logic [1:0] mask;
  always_comb begin
    cmd = sdram_pin_pkg::cmd_t'({pins_reg.cs_n, pins_reg.ras_n,
                                  pins_reg.cas_n, pins_reg.we_n});
    if (pins_reg.cs_n) begin
      cmd = sdram_pin_pkg::CMD_NOP;
    end
    bank = {pins_reg.bank_select_bit1, pins_reg.bank_select_bit0};
    mask = {pins_reg.high_byte_mask, pins_reg.low_byte_mask};
  end

  // per-bank row and burst state
  logic [ADDR_W-1:0] row_reg [NB], row_next [NB];
  logic [NB-1:0] open_reg, open_next, pre_reg, pre_next;
  burst_t st_reg, st_next;
  logic [BW-1:0] bbank_reg, bbank_next;
  logic [CW-1:0] col_reg, col_next;
  logic [3:0] cnt_reg, cnt_next;
  logic ap_reg, ap_next;
  logic [BW+ADDR_W-1:0] op_reg, op_next;
  logic ml_reg, ml_next;
  logic [3:0] rdly_reg, rdly_next;

  always_comb begin
    row_next = row_reg;
    open_next = open_reg;
    pre_next = '0;
    st_next = st_reg;
    bbank_next = bbank_reg;
    col_next = col_reg;
    cnt_next = cnt_reg;
    ap_next = ap_reg;
    op_next = op_reg;
    ml_next = 1'b0;
    rdly_next = rdly_reg;
    // running burst advances regardless of chip select
    if (st_reg != IDLE) begin
      if (rdly_reg != 4'h0) begin
        rdly_next = rdly_reg - 4'h1;
      end else begin
        col_next = col_reg + CW'(1);
        if (cnt_reg == 4'h1) begin
          st_next = IDLE;
          if (ap_reg) begin
            open_next[bbank_reg] = 1'b0;
            pre_next[bbank_reg] = 1'b1;
          end
        end
        cnt_next = cnt_reg - 4'h1;
      end
    end
    case (cmd)
      sdram_pin_pkg::CMD_ACTIVE: begin
        row_next[bank] = pins_reg.addr;
        open_next[bank] = 1'b1;
      end
      sdram_pin_pkg::CMD_READ, sdram_pin_pkg::CMD_WRITE: begin
        st_next = (cmd == sdram_pin_pkg::CMD_READ) ? RD_BURST : WR_BURST;
        bbank_next = bank;
        ap_next = pins_reg.addr[sdram_pin_pkg::FLAG_BIT];
        if (cmd == sdram_pin_pkg::CMD_READ) begin
          col_next = pins_reg.addr[CW-1:0];
          cnt_next = sdram_pin_pkg::BURST_LEN;
          rdly_next = sdram_pin_pkg::READ_LAT - 4'h1;
        end else begin
          // command edge already stored beat 0, so the burst goes on one column later
          col_next = pins_reg.addr[CW-1:0] + CW'(1);
          cnt_next = sdram_pin_pkg::BURST_LEN - 4'h1;
          rdly_next = 4'h0;
        end
      end
      sdram_pin_pkg::CMD_PRECHARGE: begin
        if (pins_reg.addr[sdram_pin_pkg::FLAG_BIT]) begin
          open_next = '0;
          pre_next = '1;
        end else begin
          open_next[bank] = 1'b0;
          pre_next[bank] = 1'b1;
        end
      end
      sdram_pin_pkg::CMD_MODE: begin
        op_next = {bank, pins_reg.addr};
        ml_next = 1'b1;
      end
      sdram_pin_pkg::CMD_TERMINATE: begin
        st_next = IDLE;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NB; i++) begin
        row_reg[i] <= '0;
      end
      open_reg <= '0;
      pre_reg <= '0;
      st_reg <= IDLE;
      bbank_reg <= '0;
      col_reg <= '0;
      cnt_reg <= 4'h0;
      ap_reg <= 1'b0;
      op_reg <= '0;
      ml_reg <= 1'b0;
      rdly_reg <= 4'h0;
    end else begin
      row_reg <= row_next;
      open_reg <= open_next;
      pre_reg <= pre_next;
      st_reg <= st_next;
      bbank_reg <= bbank_next;
      col_reg <= col_next;
      cnt_reg <= cnt_next;
      ap_reg <= ap_next;
      op_reg <= op_next;
      ml_reg <= ml_next;
      rdly_reg <= rdly_next;
    end
  end

  // storage: address formed from bank, low row bits and column
  logic wr_beat;
  logic [1:0] wr_lane_en;
  logic [MAW-1:0] mem_addr;
  logic [DATA_W-1:0] rd_data;
  always_comb begin
    wr_beat = (st_reg == WR_BURST) || (cmd == sdram_pin_pkg::CMD_WRITE);
    wr_lane_en = wr_beat ? ~mask : 2'b00;
    if (cmd == sdram_pin_pkg::CMD_WRITE) begin
      mem_addr = MAW'({bank, row_reg[bank][1:0], pins_reg.addr[3:0]});
    end else begin
      mem_addr = MAW'({bbank_reg, row_reg[bbank_reg][1:0], col_reg[3:0]});
    end
  end

  lane_mem #(.AW(MAW), .DW(DATA_W), .LW(sdram_pin_pkg::LANE_W)) u_mem (
    .ref_clk(ref_clk),
    .wr_addr(mem_addr),
    .wr_data(din_reg),
    .wr_lane_en(wr_lane_en),
    .rd_addr(mem_addr),
    .rd_data(rd_data)
  );

  // read output: drive while burst beats flow, mask delayed two clocks
  logic [1:0] mdly_reg [LAT-1], mdly_next [LAT-1];
  logic rd_act_reg, rd_act_next;
  logic [1:0] oe_reg, oe_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  always_comb begin
    mdly_next[0] = mask;
    for (int i = 1; i < LAT - 1; i++) begin
      mdly_next[i] = mdly_reg[i-1];
    end
    rd_act_next = (st_reg == RD_BURST) && (rdly_reg == 4'h0);
    // mask sampled at edge n floats the lane from edge n+2
    oe_next = rd_act_reg ? ~mdly_reg[LAT-2] : 2'b00;
    dout_next = rd_data;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < LAT - 1; i++) begin
        mdly_reg[i] <= 2'b00;
      end
      rd_act_reg <= 1'b0;
      oe_reg <= 2'b00;
      dout_reg <= '0;
    end else begin
      mdly_reg <= mdly_next;
      rd_act_reg <= rd_act_next;
      oe_reg <= oe_next;
      dout_reg <= dout_next;
    end
  end

  assign data_bus_out = dout_reg;
  assign data_bus_oe = oe_reg;
  assign mode_op_code = op_reg;
  assign mode_load = ml_reg;
  assign bank_open = open_reg;
  assign precharge_done = pre_reg;
  assign auto_precharge = ap_reg;
endmodule : sdram_pin_front

//--- verilog/sdram_pin_pkg.sv
// shared constants and carrier types for the memory pin front end
package sdram_pin_pkg;
  localparam int ADDR_W = 12;
  localparam int COL_W = 9;
  localparam int BANK_W = 2;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int NUM_BANKS = 4;
  localparam int FLAG_BIT = 10;
  localparam int MASK_LAT = 2;
  localparam int BURST_W = 4;
  localparam logic [BURST_W-1:0] BURST_LEN = 4'h4;
  localparam logic [BURST_W-1:0] READ_LAT = 4'h2;
  localparam int MEM_AW = 8;

  // command code {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_MODE = 4'h0,
    CMD_REFRESH = 4'h1,
    CMD_PRECHARGE = 4'h2,
    CMD_ACTIVE = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_READ = 4'h5,
    CMD_TERMINATE = 4'h6,
    CMD_NOP = 4'h7
  } cmd_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_select_bit1;
    logic bank_select_bit0;
    logic [ADDR_W-1:0] addr;
    logic high_byte_mask;
    logic low_byte_mask;
  } pins_t;

  typedef struct packed {
    logic [BANK_W+ADDR_W-1:0] op_code;
    logic valid;
  } mode_t;
endpackage : sdram_pin_pkg

//--- verilog/lane_mem.sv
`timescale 1ns/10ps
// small byte-lane storage with registered read data
module lane_mem #(
  parameter int AW = 8,
  parameter int DW = 16,
  parameter int LW = 8
) (
  input wire logic ref_clk,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [DW/LW-1:0] wr_lane_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < DW/LW; i++) begin
      if (wr_lane_en[i]) begin
        mem[wr_addr][i*LW +: LW] <= wr_data[i*LW +: LW];
      end
    end
    rd_data <= mem[rd_addr];
  end
endmodule : lane_mem

//--- verif/sdram_pin_front_monitor.sv
`timescale 1ns/10ps
// port assertions for the memory pin front end
module sdram_pin_front_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_bit0,
  input wire logic bank_select_bit1,
  input wire logic [11:0] addr,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic [1:0] data_bus_oe,
  input wire logic [13:0] mode_op_code,
  input wire logic mode_load,
  input wire logic [3:0] bank_open,
  input wire logic [3:0] precharge_done,
  input wire logic auto_precharge
);
  logic [3:0] cmd;
  logic [1:0] bank;
  logic [1:0] msk;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign bank = {bank_select_bit1, bank_select_bit0};
  assign msk = {high_byte_mask, low_byte_mask};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  mode_pulse_a: assert property (mode_load |-> $past(cmd, 2) == 4'h0)
    else $error("mode load without its command");
  mode_code_a: assert property (mode_load |->
    mode_op_code == {$past(bank, 2), $past(addr, 2)}) else $error("mode code wrong");
  cs_block_a: assert property ($past(cs_n, 2) |-> !mode_load)
    else $error("deselected command acted");
  row_open_a: assert property ($past(cmd, 2) == 4'h3 |-> bank_open[$past(bank, 2)])
    else $error("activated bank not open");
  pre_one_a: assert property ($past(cmd, 2) == 4'h2 && !$past(addr[10], 2) |->
    precharge_done[$past(bank, 2)] && !bank_open[$past(bank, 2)]) else $error("bank precharge");
  pre_all_a: assert property ($past(cmd, 2) == 4'h2 && $past(addr[10], 2) |->
    bank_open == 4'h0) else $error("all bank precharge");
  auto_flag_a: assert property ($past(cmd, 2) inside {4'h4, 4'h5} |->
    auto_precharge == $past(addr[10], 2)) else $error("auto precharge flag");
  mask_float_a: assert property (($past(msk, 3) & data_bus_oe) == 2'h0)
    else $error("masked lane still driven");
endmodule : sdram_pin_front_monitor

bind sdram_pin_front sdram_pin_front_monitor i_mon (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_bit0(bank_select_bit0),
  .bank_select_bit1(bank_select_bit1), .addr(addr), .low_byte_mask(low_byte_mask),
  .high_byte_mask(high_byte_mask), .data_bus_oe(data_bus_oe), .mode_op_code(mode_op_code),
  .mode_load(mode_load), .bank_open(bank_open), .precharge_done(precharge_done),
  .auto_precharge(auto_precharge));

//--- verif/mem_ctrl_model.sv
`timescale 1ns/10ps
// controller stand-in launching pins and write data on the rising edge
module mem_ctrl_model (
  input wire logic ref_clk,
  input wire sdram_pin_pkg::pins_t req,
  input wire logic [15:0] wdata,
  input wire logic wdrive,
  output sdram_pin_pkg::pins_t pins,
  output logic [15:0] data
);
  initial begin
    pins = 20'hf0000;
    data = 16'h0;
  end
  always @(posedge ref_clk) begin
    pins <= req;
    // idle bus toggles so stale write data never looks valid
    data <= wdrive ? wdata : ~data;
  end
endmodule : mem_ctrl_model

//--- verif/tb_top.sv
`timescale 1ns/10ps
// pin front end bench: mode, banks, precharge, bursts, masks and deselect
module tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  sdram_pin_pkg::pins_t req = 20'hf0000;
  sdram_pin_pkg::pins_t pins;
  logic [15:0] wdata = 16'h0;
  logic wdrive = 1'b0;
  logic [15:0] data_in;
  logic [15:0] data_out;
  logic [1:0] oe;
  logic [13:0] op;
  logic mload;
  logic apre;
  logic [3:0] bopen;
  logic [3:0] pdone;
  int miscompares = 0;
  int samples_checked = 0;
  mem_ctrl_model i_ctrl (.ref_clk(ref_clk), .req(req), .wdata(wdata), .wdrive(wdrive),
    .pins(pins), .data(data_in));
  sdram_pin_front i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(pins.cs_n),
    .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
    .bank_select_bit0(pins.bank_select_bit0), .bank_select_bit1(pins.bank_select_bit1),
    .addr(pins.addr), .low_byte_mask(pins.low_byte_mask), .high_byte_mask(pins.high_byte_mask),
    .data_bus_in(data_in), .data_bus_out(data_out), .data_bus_oe(oe), .mode_op_code(op),
    .mode_load(mload), .bank_open(bopen), .precharge_done(pdone), .auto_precharge(apre));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic issue(logic [3:0] c, logic [1:0] b, logic [11:0] a, logic [1:0] m);
    @(posedge ref_clk);
    req <= {c, b, a, m};
    @(posedge ref_clk);
    req <= {4'hf, b, a, m};
  endtask : issue
  task automatic t_mode;
    int hits = 0;
    issue(4'h0, 2'h2, 12'h5a3, 2'h0);
    repeat (5) begin
      @(posedge ref_clk);
      #1 hits += mload;
    end
    check("mode_op_code", 16'h25a3, {2'h0, op});
    issue(4'h8, 2'h1, 12'h0f0, 2'h0);
    repeat (5) begin
      @(posedge ref_clk);
      #1 hits += mload;
    end
    check("mode_load count", 16'h1, 16'(hits));
    check("mode_op_code", 16'h25a3, {2'h0, op});
  endtask : t_mode
  task automatic t_bank;
    logic [3:0] seen = 4'h0;
    for (int b = 0; b < 4; b++) begin
      issue(4'h3, 2'(b), 12'h8a1, 2'h0);
    end
    repeat (3) @(posedge ref_clk);
    #1 check("bank_open", 16'hf, {12'h0, bopen});
    issue(4'h2, 2'h1, 12'h000, 2'h0);
    repeat (4) begin
      @(posedge ref_clk);
      #1 seen |= pdone;
    end
    check("precharge_done", 16'h2, {12'h0, seen});
    check("bank_open", 16'hd, {12'h0, bopen});
    issue(4'h2, 2'h0, 12'h400, 2'h0);
    repeat (4) @(posedge ref_clk);
    #1 check("bank_open", 16'h0, {12'h0, bopen});
  endtask : t_bank
  task automatic wr(logic [11:0] a, logic [15:0] base, logic [1:0] m);
    fork
      issue(4'h4, 2'h0, a, m);
      begin
        @(posedge ref_clk);
        for (int k = 0; k < 4; k++) begin
          wdrive <= 1'b1;
          wdata <= base + 16'(k);
          @(posedge ref_clk);
        end
        wdrive <= 1'b0;
      end
    join
  endtask : wr
  task automatic rd(logic [11:0] a, logic [1:0] m, logic [15:0] base);
    int n = 0;
    logic [15:0] keep;
    keep = {{8{~m[1]}}, {8{~m[0]}}};
    issue(4'h5, 2'h0, a, m);
    #1;
    while (oe === 2'h0 && n < 10) begin
      @(posedge ref_clk);
      #1 n++;
    end
    for (int k = 0; k < 4; k++) begin
      check("data_bus_oe", {14'h0, ~m}, {14'h0, oe});
      check("data_bus_out", (base + 16'(k)) & keep, data_out & keep);
      @(posedge ref_clk);
      #1;
    end
  endtask : rd
  task automatic t_burst;
    issue(4'h3, 2'h0, 12'h000, 2'h0);
    wr(12'h004, 16'h1230, 2'h0);
    #1 check("auto_precharge", 16'h0, {15'h0, apre});
    // auto precharge on the masked write closes the bank before the reads
    wr(12'h404, 16'hab00, 2'h2);
    #1 check("auto_precharge", 16'h1, {15'h0, apre});
    repeat (3) @(posedge ref_clk);
    #1 check("bank_open", 16'h0, {12'h0, bopen});
    issue(4'h3, 2'h0, 12'h000, 2'h0);
    rd(12'ha04, 2'h0, 16'h1200);
    check("auto_precharge", 16'h0, {15'h0, apre});
    rd(12'h404, 2'h1, 16'h1200);
    check("auto_precharge", 16'h1, {15'h0, apre});
    repeat (6) @(posedge ref_clk);
    #1 check("bank_open", 16'h0, {12'h0, bopen});
  endtask : t_burst
  task automatic t_lane;
    logic [7:0] seen;
    issue(4'h3, 2'h0, 12'h000, 2'h0);
    issue(4'h5, 2'h0, 12'h004, 2'h0);
    // low mask up for one edge only, so the float window shows the latency
    @(posedge ref_clk);
    req.low_byte_mask <= 1'b1;
    @(posedge ref_clk);
    req.low_byte_mask <= 1'b0;
    repeat (3) @(posedge ref_clk);
    for (int k = 0; k < 4; k++) begin
      #1 seen[2*k +: 2] = oe;
      @(posedge ref_clk);
    end
    check("data_bus_oe beats", 16'h00fe, {8'h0, seen});
  endtask : t_lane
  task automatic t_stop;
    int n = 0;
    issue(4'h5, 2'h0, 12'h004, 2'h0);
    issue(4'h6, 2'h0, 12'h000, 2'h0);
    repeat (8) begin
      @(posedge ref_clk);
      #1 n += 32'(oe !== 2'h0);
    end
    check("terminated beats", 16'h1, 16'(n));
  endtask : t_stop
  task automatic conclude;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  initial begin
    #20000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_mode();
    t_bank();
    t_burst();
    t_lane();
    t_stop();
    conclude();
  end
endmodule : tb_top
